// ---- design/eag_core.sv ----
// Functional notes
// - Offset is base plus scaled index plus displacement.
// - Linear address adds segment base to offset.
// - Scale 1/2/4/8, only with 32-bit addressing.
// - Stack pointer never serves as index.
// - Any 32-bit register may be base.
// - 32-bit displacement: none, 8 or 32 bits.
// - 16-bit form: legacy base/index, 8/16 displacement.
// - Base plus index costs one extra clock.
// - Direct mode uses displacement alone.
// - Register operand at 8, 16 or 32 bits.
// - Immediate operand from instruction, no memory.
// - Code segment flag selects 16 or 32 default.
// - Real mode defaults to 16 bits.
// - Size prefixes toggle defaults per instruction.
// - Both prefixes accepted, independently, any instruction.
// - Real mode offset above 16-bit limit faults.
module eag_core
	import eag_pkg::*;
#(
	parameter int NREG = 8
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_b,
	input  wire logic              i_req_valid,
	input  wire eag_pkg::eag_req_t i_req,
	input  wire logic [NREG*32-1:0] i_gpr,
	output logic                   o_req_ready,
	output logic                   o_rsp_valid,
	output eag_pkg::eag_rsp_t      o_rsp
);
	import eag_pkg::*;

	typedef enum logic [0:0] {
		EAG_ST_IDLE  = 1'b0,
		EAG_ST_EXTRA = 1'b1
	} eag_state_t;

	logic [31:0] gpr [NREG];
	eag_state_t  state;
	eag_req_t    held;
	eag_req_t    cur;
	logic        op32;
	logic        addr32;
	logic        base_ok;
	logic        index_ok;
	logic [31:0] base_val;
	logic [31:0] index_val;
	logic [31:0] scaled;
	logic [31:0] disp_val;
	logic [31:0] sum;
	logic [32:0] sum_wide;
	logic [31:0] next_offset;
	logic [31:0] reg_val;
	logic [31:0] next_operand;
	eag_width_t  next_width;
	logic        needs_extra;
	logic        take;

	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_gpr
			assign gpr[g] = i_gpr[g*32 +: 32];
		end
	endgenerate

	// Second cycle of a base plus index form works on the held request.
	assign cur = (state == EAG_ST_EXTRA) ? held : i_req;

	eag_size_select u_size (
		.i_cs_size_flag    (cur.cs_size_flag),
		.i_real_mode       (cur.real_mode),
		.i_opsize_prefix   (cur.opsize_prefix),
		.i_addrsize_prefix (cur.addrsize_prefix),
		.o_op32            (op32),
		.o_addr32          (addr32)
	);

	always_comb begin
		base_ok  = 1'b0;
		index_ok = 1'b0;
		if (addr32) begin
			base_ok  = cur.use_base;
			index_ok = cur.use_index && (cur.index_sel != REG_SP);
		end else begin
			base_ok  = cur.use_base &&
				(cur.base_sel == REG_B || cur.base_sel == REG_FRAME);
			index_ok = cur.use_index &&
				(cur.index_sel == REG_SRC_IX || cur.index_sel == REG_DST_IX);
		end
	end

	assign base_val  = base_ok ? gpr[cur.base_sel] : 32'h0;
	assign index_val = index_ok ? gpr[cur.index_sel] : 32'h0;
	assign scaled    = addr32 ? (index_val << cur.scale_log2) : index_val;

	always_comb begin
		disp_val = 32'h0;
		unique case (cur.disp_kind)
			EAG_DISP_NONE: disp_val = 32'h0;
			EAG_DISP_8:    disp_val = {{24{cur.disp_bytes[7]}}, cur.disp_bytes[7:0]};
			EAG_DISP_WIDE: begin
				if (addr32) begin
					disp_val = cur.disp_bytes;
				end else begin
					disp_val = {16'h0, cur.disp_bytes[15:0]};
				end
			end
			default:       disp_val = 32'h0;
		endcase
	end

	// Direct mode falls out with no base and no index selected.
	assign sum_wide = {1'b0, base_val} + {1'b0, scaled} + {1'b0, disp_val};
	assign sum      = sum_wide[31:0];
	assign next_offset = addr32 ? sum : (sum & MASK16);

	always_comb begin
		reg_val    = gpr[cur.reg_sel];
		next_width = EAG_W16;
		if (cur.reg_byte) begin
			next_width = EAG_W8;
		end else if (op32) begin
			next_width = EAG_W32;
		end
		next_operand = 32'h0;
		unique case (next_width)
			EAG_W8:  next_operand = {24'h0, reg_val[7:0]};
			EAG_W16: next_operand = {16'h0, reg_val[15:0]};
			EAG_W32: next_operand = reg_val;
			default: next_operand = reg_val;
		endcase
		if (cur.kind == EAG_OPK_IMM) begin
			next_operand = cur.imm;
		end
	end

	assign needs_extra = (cur.kind == EAG_OPK_MEM) && base_ok && index_ok;
	assign take        = i_req_valid && (state == EAG_ST_IDLE);

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= EAG_ST_IDLE;
		end else if (take && needs_extra) begin
			state <= EAG_ST_EXTRA;
		end else begin
			state <= EAG_ST_IDLE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			held <= '0;
		end else if (take) begin
			held <= i_req;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_req_ready <= 1'b1;
		end else begin
			o_req_ready <= !(take && needs_extra);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rsp_valid <= 1'b0;
			o_rsp       <= '0;
		end else if ((take && !needs_extra) || state == EAG_ST_EXTRA) begin
			o_rsp_valid                <= 1'b1;
			o_rsp.effective_offset     <= next_offset;
			o_rsp.linear_address       <= cur.seg_base + next_offset;
			o_rsp.is_memory            <= (cur.kind == EAG_OPK_MEM);
			o_rsp.operand_valid        <= (cur.kind != EAG_OPK_MEM);
			o_rsp.operand              <= next_operand;
			o_rsp.addr32               <= addr32;
			o_rsp.op32                 <= op32;
			o_rsp.width                <= next_width;
			o_rsp.prot_fault           <= (cur.kind == EAG_OPK_MEM) && cur.real_mode &&
				(sum_wide > {1'b0, REAL_LIMIT});
		end else begin
			o_rsp_valid <= 1'b0;
		end
	end
endmodule // eag_core

// ---- design/eag_pkg.sv ----
package eag_pkg;
	localparam int REG_NUM   = 8;
	localparam int REG_IDX_W = 3;
	localparam int ADDR_W    = 32;

	// General register numbers used by the address forms.
	localparam logic [2:0] REG_B      = 3'h3;
	localparam logic [2:0] REG_SP     = 3'h4;
	localparam logic [2:0] REG_FRAME  = 3'h5;
	localparam logic [2:0] REG_SRC_IX = 3'h6;
	localparam logic [2:0] REG_DST_IX = 3'h7;

	localparam logic [31:0] REAL_LIMIT = 32'h0000ffff;
	localparam logic [31:0] MASK16     = 32'h0000ffff;

	typedef enum logic [1:0] {
		EAG_OPK_REG = 2'h0,
		EAG_OPK_IMM = 2'h1,
		EAG_OPK_MEM = 2'h2
	} eag_opkind_t;

	typedef enum logic [1:0] {
		EAG_DISP_NONE = 2'h0,
		EAG_DISP_8    = 2'h1,
		EAG_DISP_WIDE = 2'h2
	} eag_disp_t;

	typedef enum logic [1:0] {
		EAG_W8  = 2'h0,
		EAG_W16 = 2'h1,
		EAG_W32 = 2'h2
	} eag_width_t;

	typedef struct packed {
		eag_opkind_t kind;
		logic        use_base;
		logic [2:0]  base_sel;
		logic        use_index;
		logic [2:0]  index_sel;
		logic [1:0]  scale_log2;
		eag_disp_t   disp_kind;
		logic [31:0] disp_bytes;
		logic [31:0] imm;
		logic [2:0]  reg_sel;
		logic        reg_byte;
		logic [31:0] seg_base;
		logic        cs_size_flag;
		logic        real_mode;
		logic        opsize_prefix;
		logic        addrsize_prefix;
	} eag_req_t;

	typedef struct packed {
		logic [31:0] linear_address;
		logic [31:0] effective_offset;
		logic [31:0] operand;
		logic        operand_valid;
		logic        is_memory;
		logic        addr32;
		logic        op32;
		eag_width_t  width;
		logic        prot_fault;
	} eag_rsp_t;
endpackage : eag_pkg

// ---- design/eag_size_select.sv ----
module eag_size_select (
	input  wire logic i_cs_size_flag,
	input  wire logic i_real_mode,
	input  wire logic i_opsize_prefix,
	input  wire logic i_addrsize_prefix,
	output logic      o_op32,
	output logic      o_addr32
);
	logic default32;

	assign default32 = i_real_mode ? 1'b0 : i_cs_size_flag;
	assign o_op32    = default32 ^ i_opsize_prefix;
	assign o_addr32  = default32 ^ i_addrsize_prefix;
endmodule // eag_size_select

// ---- verif/eag_core_assertions.sv ----
module eag_chk
	import eag_pkg::*;
#(
	parameter int NREG = 8
) (
	input wire logic               i_clk,
	input wire logic               i_rst_b,
	input wire logic               i_req_valid,
	input wire eag_pkg::eag_req_t  i_req,
	input wire logic [NREG*32-1:0] i_gpr,
	input wire logic               o_req_ready,
	input wire logic               o_rsp_valid,
	input wire eag_pkg::eag_rsp_t  o_rsp
);
	eag_req_t q;
	wire t = i_req_valid && o_req_ready;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	always_ff @(posedge i_clk) if (t) q <= i_req;
	a_stall_one: assert property (!o_req_ready |=> o_req_ready && o_rsp_valid)
		else $error("stall");
	a_simple_lat: assert property (t && i_req.kind != EAG_OPK_MEM |=> o_rsp_valid)
		else $error("latency");
	a_op_size: assert property (o_rsp_valid |->
		o_rsp.op32 == ((q.cs_size_flag && !q.real_mode) ^ q.opsize_prefix)) else $error("op");
	a_addr_size: assert property (o_rsp_valid |->
		o_rsp.addr32 == ((q.cs_size_flag && !q.real_mode) ^ q.addrsize_prefix)) else $error("ad");
	a_linear_sum: assert property (o_rsp_valid && o_rsp.is_memory |->
		o_rsp.linear_address == o_rsp.effective_offset + q.seg_base) else $error("linear");
	a_off_narrow: assert property (o_rsp_valid && o_rsp.is_memory && !o_rsp.addr32 |->
		o_rsp.effective_offset[31:16] == 16'h0) else $error("narrow");
	a_fault_src: assert property (o_rsp_valid && o_rsp.prot_fault |->
		q.real_mode && q.kind == EAG_OPK_MEM) else $error("fault");
	a_no_memory: assert property (o_rsp_valid && q.kind != EAG_OPK_MEM |->
		o_rsp.operand_valid && !o_rsp.is_memory) else $error("operand");
	c_stall: cover property (!o_req_ready);
	c_fault: cover property (o_rsp_valid && o_rsp.prot_fault);
	c_wide: cover property (o_rsp_valid && o_rsp.is_memory && o_rsp.addr32);
endmodule // eag_chk

bind eag_core eag_chk #(.NREG(NREG)) u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_req_valid(i_req_valid), .i_req(i_req), .i_gpr(i_gpr), .o_req_ready(o_req_ready),
	.o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp));

// ---- verif/eag_gpr_model.sv ----
module eag_gpr_model #(
	parameter int NREG = 8
) (
	output logic [NREG*32-1:0] o_gpr
);
	timeunit 1ns;
	timeprecision 1ns;
	// Small register values keep every unscaled offset sum clear of a 32-bit wrap.
	initial for (int n = 0; n < NREG; n++) o_gpr[n*32+:32] = $urandom & 32'h0fffffff;
endmodule // eag_gpr_model

// ---- verif/test_effective_address_generator.sv ----
module test_effective_address_generator;
	timeunit 1ns;
	timeprecision 1ns;
	import eag_pkg::*;
	logic         i_clk = 0, i_rst_b = 0, i_req_valid = 0, tk = 0;
	eag_req_t     i_req = '0;
	eag_req_t     q[$];
	eag_rsp_t     o_rsp;
	logic         o_req_ready, o_rsp_valid;
	logic [255:0] gpr;
	logic [32:0]  e;
	int           num_errors = 0, compares = 0;
	eag_core dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid), .i_req(i_req),
		.i_gpr(gpr), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp));
	eag_gpr_model gm (.o_gpr(gpr));
	initial forever #10 i_clk = ~i_clk;
	function automatic logic [32:0] expect_off(eag_req_t r);
		logic        a;
		logic [33:0] s;
		a = (r.cs_size_flag && !r.real_mode) ^ r.addrsize_prefix;
		s = 34'(r.disp_kind == EAG_DISP_8 ? {{24{r.disp_bytes[7]}}, r.disp_bytes[7:0]} :
			r.disp_kind == EAG_DISP_WIDE ? (a ? r.disp_bytes : {16'h0, r.disp_bytes[15:0]}) : 32'h0);
		if (r.use_base && (a || r.base_sel inside {REG_B, REG_FRAME}))
			s += 34'(gpr[r.base_sel*32+:32]);
		if (r.use_index && (a ? r.index_sel != REG_SP : r.index_sel inside {REG_SRC_IX, REG_DST_IX}))
			s += 34'(gpr[r.index_sel*32+:32]) << (a ? r.scale_log2 : 2'h0);
		return {r.real_mode && r.kind == EAG_OPK_MEM && s > 34'hffff, a ? s[31:0] : {16'h0, s[15:0]}};
	endfunction
	// Expected width code in the top bits, expected operand value below.
	function automatic logic [33:0] expect_opd(eag_req_t r);
		logic [31:0] v;
		logic [1:0]  w;
		v = gpr[r.reg_sel*32+:32];
		w = r.reg_byte ? 2'h0 : (((r.cs_size_flag && !r.real_mode) ^ r.opsize_prefix) ? 2'h2 : 2'h1);
		v = (w == 2'h0) ? {24'h0, v[7:0]} : ((w == 2'h1) ? {16'h0, v[15:0]} : v);
		return {w, (r.kind == EAG_OPK_IMM) ? r.imm : v};
	endfunction
	function automatic eag_req_t rnd();
		logic [127:0] v;
		eag_req_t     r;
		v = {$urandom, $urandom, $urandom, $urandom};
		r = v[$bits(eag_req_t)-1:0];
		r.kind = eag_opkind_t'($urandom_range(2));
		r.disp_kind = eag_disp_t'($urandom_range(2));
		r.disp_bytes &= 32'h7fffff7f;
		return r;
	endfunction
	task chk(input logic [31:0] g, x);
		compares++;
		if (g !== x) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	// The request is held until an edge takes it, so refused cycles never lose one.
	task put(input eag_req_t r, input logic v);
		i_req_valid = v;
		i_req = r;
		do @(negedge i_clk); while (v && !tk);
	endtask
	task end_sim();
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		if (i_rst_b && i_req_valid && o_req_ready) q.push_back(i_req);
		tk <= i_rst_b && i_req_valid && o_req_ready;
	end
	always @(negedge i_clk) if (o_rsp_valid === 1'b1) begin
		e = expect_off(q[0]);
		chk(32'(o_rsp.prot_fault), 32'(e[32]));
		chk(32'(o_rsp.is_memory), 32'(q[0].kind == EAG_OPK_MEM));
		if (q[0].kind == EAG_OPK_MEM) begin
			chk(o_rsp.effective_offset, e[31:0]);
			chk(o_rsp.linear_address, e[31:0] + q[0].seg_base);
		end else begin
			chk(o_rsp.operand, 32'(expect_opd(q[0])));
			chk(32'(o_rsp.width), 32'(expect_opd(q[0]) >> 32));
		end
		void'(q.pop_front());
	end
	initial begin
		eag_req_t c;
		void'($urandom(79));
		repeat (5) @(negedge i_clk);
		i_rst_b = 1;
		chk(32'(o_req_ready), 32'h1);
		chk(32'(o_rsp_valid), 32'h0);
		for (int k = 0; k < 4; k++) begin
			c = '0;
			c.kind = EAG_OPK_MEM;
			c.disp_kind = EAG_DISP_WIDE;
			c.disp_bytes = 32'h0000ffff + k[0];
			c.real_mode = 1'b1;
			c.addrsize_prefix = !k[1];
			c.use_base = k[1];
			c.base_sel = REG_FRAME;
			c.use_index = k[1];
			c.index_sel = REG_DST_IX;
			c.seg_base = 32'h00012340;
			put(c, 1'b1);
		end
		repeat (600) put(rnd(), 1'(($urandom & 3) != 0));
		put('0, 1'b0);
		repeat (3) @(negedge i_clk);
		end_sim();
	end
	initial begin
		#50us;
		num_errors++;
		end_sim();
	end
endmodule // test_effective_address_generator
